// [rtl/fmps_supervisor.sv]
// The register addresses and the APB interface to the registers were decided locally.
`include "fmps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module fmps_supervisor #(
    parameter int unsigned TICK_CYC = `FMPS_TICK_CYC,
    parameter int unsigned DUTY_W = 8,
    parameter logic [7:0] HYST_DUTY = 8'h04
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host command side
    input wire logic [DUTY_W-1:0] pwm_duty,
    input wire logic pwm_rise,
    // Motor side
    input wire logic hall_phase_change,
    input wire fmps_pkg::fmps_sense_t current_sense_pin,
    input wire fmps_pkg::fmps_gates_t run_gates,
    input wire fmps_pkg::fmps_gates_t recirc_gates,
    output fmps_pkg::fmps_gates_t gates,
    // Straps
    input wire logic supply_class_high,
    input wire logic polarity_check_disable_pin,
    input wire logic high_gate_a_sense,
    input wire logic high_gate_b_sense,
    input wire logic serial_mode_pin,
    // Tach pin and serial link
    input wire logic speed_pulse,
    input wire logic ser_tx,
    output logic ser_rx,
    input wire logic tach_output_pin_i,
    output logic tach_output_pin_o,
    output logic tach_output_pin_oe,
    input wire logic pwm_pin_i
);

    // ****************************************
    // Nonvolatile image and setting registers
    // ****************************************
    // Store image survives presetn, so it has no reset branch
    logic [31:0] nvm_mem [`FMPS_NVM_WORDS] = '{`FMPS_CTRL_RST,
        `FMPS_PROT_RST, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] ctrl_ff;
    logic [31:0] prot_ff;
    logic reload_ff;

    function automatic logic [11:0] word_ofs(input logic [11:0] a);
        word_ofs = {a[11:2], 2'b00};
    endfunction

    wire logic wr_en = psel && penable && pwrite;
    wire logic [11:0] wofs = word_ofs(paddr);

    always_ff @(posedge pclk)
    begin
        if (wr_en && wofs == `FMPS_OFS_NVM && pwdata[31])
        begin
            nvm_mem[0] <= ctrl_ff;
            nvm_mem[1] <= prot_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reload_ff <= 1'b1;
        else
            reload_ff <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= `FMPS_CTRL_RST;
            prot_ff <= `FMPS_PROT_RST;
        end
        else if (reload_ff)
        begin
            ctrl_ff <= nvm_mem[0];
            prot_ff <= nvm_mem[1];
        end
        else if (wr_en && wofs == `FMPS_OFS_CTRL)
            ctrl_ff <= pwdata;
        else if (wr_en && wofs == `FMPS_OFS_PROT)
            prot_ff <= pwdata;
    end

    fmps_pkg::fmps_tach_pin_function_select_t tach_pin_function_select;
    logic [3:0] duty_stop_set;
    logic [1:0] blank_sel;
    assign tach_pin_function_select = fmps_pkg::fmps_tach_pin_function_select_t'(
        ctrl_ff[`FMPS_CTRL_TACH_PIN_FUNCTION_SELECT_LSB +: 2]);
    assign duty_stop_set = ctrl_ff[`FMPS_CTRL_DUTYS_LSB +: 4];
    assign blank_sel = prot_ff[`FMPS_PROT_MASK_LSB +: 2];

    // ****************************************
    // Timebase
    // ****************************************
    logic [31:0] tick_cnt_ff;
    logic tick;
    assign tick = (tick_cnt_ff == TICK_CYC - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_ff <= 32'h0000_0000;
        else if (tick)
            tick_cnt_ff <= 32'h0000_0000;
        else
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end

    // ****************************************
    // Stop-duty decision with hysteresis
    // ****************************************
    // Threshold scaled as 5*code/255 of full duty, code 15 gives threshold 75, no code disables it
    logic [DUTY_W-1:0] stop_thr;
    logic stop_ff;
    assign stop_thr = DUTY_W'({duty_stop_set, 2'b00} + {4'h0, duty_stop_set});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_ff <= 1'b1;
        else if (pwm_duty <= stop_thr)
            stop_ff <= 1'b1;
        else if (pwm_duty > stop_thr + HYST_DUTY)
            stop_ff <= 1'b0;
    end

    // ****************************************
    // Lock detection and retry sequence
    // ****************************************
    typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT, ST_LATCH} st_e;
    st_e st_ff;
    logic [15:0] idle_ff;
    logic [15:0] off_ff;
    logic [2:0] events_ff;
    logic [2:0] phases_ff;
    logic lock_ind_ff;
    logic ocp_hit;
    logic ocp_latch_mode;

    assign ocp_latch_mode = !prot_ff[`FMPS_PROT_RESP_BIT];

    function automatic logic [15:0] off_len(input logic [2:0] n);
        off_len = (n >= 3'(`FMPS_LONG_EVENT)) ?
            16'(`FMPS_OFF_LONG_TICKS) : 16'(`FMPS_OFF_SHORT_TICKS);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_ff <= 16'h0000;
        else if (st_ff != ST_RUN || speed_pulse || stop_ff)
            idle_ff <= 16'h0000;
        else if (tick && idle_ff <= 16'(`FMPS_LOCK_DET_TICKS))
            idle_ff <= idle_ff + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= ST_RUN;
            off_ff <= 16'h0000;
            events_ff <= 3'h0;
        end
        else
        begin
            case (st_ff)
                ST_RUN:
                begin
                    if (ocp_hit && ocp_latch_mode)
                        st_ff <= ST_LATCH;
                    else if (ocp_hit ||
                        idle_ff > 16'(`FMPS_LOCK_DET_TICKS))
                    begin
                        st_ff <= ST_OFF;
                        if (events_ff < 3'(`FMPS_LONG_EVENT))
                            events_ff <= events_ff + 3'h1;
                        off_ff <= off_len(events_ff + 3'h1);
                    end
                end
                ST_OFF:
                begin
                    if (stop_ff && off_ff != 16'h0000)
                    begin
                        events_ff <= 3'h0;
                        st_ff <= ST_WAIT;
                    end
                    else if (off_ff == 16'h0000)
                    begin
                        if (!stop_ff)
                            st_ff <= ST_RUN;
                    end
                    else if (tick)
                        off_ff <= off_ff - 16'h0001;
                end
                ST_WAIT:
                begin
                    // At the next PWM rise with stop clear, off time is reloaded to the short length and counted down again before restart
                    if (pwm_rise && !stop_ff)
                    begin
                        st_ff <= ST_OFF;
                        if (events_ff == 3'h0)
                        begin
                            events_ff <= 3'h1;
                            off_ff <= off_len(3'h1);
                        end
                    end
                end
                ST_LATCH:
                    st_ff <= ST_LATCH;
                default:
                    st_ff <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_ind_ff <= 1'b0;
            phases_ff <= 3'h0;
        end
        else if (st_ff == ST_OFF || st_ff == ST_LATCH)
        begin
            lock_ind_ff <= 1'b1;
            phases_ff <= 3'h0;
        end
        else if (lock_ind_ff && hall_phase_change)
        begin
            if (phases_ff == 3'(`FMPS_RD_CLEAR_PHASES - 1))
                lock_ind_ff <= 1'b0;
            phases_ff <= phases_ff + 3'h1;
        end
    end

    // ****************************************
    // Current limit, blanking and overcurrent
    // ****************************************
    logic [5:0] blank_ff;
    logic [7:0] hold_ff;
    logic climit_act;
    logic sense_ok;
    assign sense_ok = (blank_ff == 6'h00);
    assign ocp_hit = sense_ok && current_sense_pin.over_shutdown && climit_act;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blank_ff <= 6'h00;
        else if (hall_phase_change)
            blank_ff <= {blank_sel, 4'hf};
        else if (blank_ff != 6'h00)
            blank_ff <= blank_ff - 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_ff <= 8'h00;
        else if (sense_ok && current_sense_pin.over_limit)
            hold_ff <= prot_ff[`FMPS_PROT_HOLD_BIT] ? 8'hff : 8'h3f;
        else if (hold_ff != 8'h00)
            hold_ff <= hold_ff - 8'h01;
    end

    assign climit_act = (hold_ff != 8'h00) || current_sense_pin.over_limit;

    // ****************************************
    // Gate polarity check at power-up
    // ****************************************
    logic gpc_done_ff;
    logic gpc_err_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpc_done_ff <= 1'b0;
            gpc_err_ff <= 1'b0;
        end
        else if (!gpc_done_ff)
        begin
            gpc_done_ff <= 1'b1;
            gpc_err_ff <= !polarity_check_disable_pin &&
                ((high_gate_a_sense == supply_class_high) ||
                 (high_gate_b_sense == supply_class_high));
        end
    end

    // ****************************************
    // Gate outputs
    // ****************************************
    fmps_pkg::fmps_gates_t nxt_gates;
    fmps_pkg::fmps_gates_t gates_ff;
    fmps_pkg::fmps_gates_t off_pat;
    assign off_pat = supply_class_high ? 4'b0000 : 4'b1010;

    always_comb
    begin
        nxt_gates = run_gates;
        if (st_ff != ST_RUN || stop_ff)
            nxt_gates = off_pat;
        else if (climit_act)
        begin
            nxt_gates = recirc_gates;
            if (prot_ff[`FMPS_PROT_ASYNC_BIT])
            begin
                nxt_gates.low_gate_a = 1'b0;
                nxt_gates.low_gate_b = 1'b0;
            end
        end
        if (gpc_err_ff || !gpc_done_ff)
        begin
            nxt_gates.low_gate_a = 1'b0;
            nxt_gates.low_gate_b = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gates_ff <= 4'b0000;
        else
            gates_ff <= nxt_gates;
    end
    assign gates = gates_ff;

    // ****************************************
    // Tach pin and serial mode
    // ****************************************
    logic tach_lvl;
    assign tach_lvl = (tach_pin_function_select == fmps_pkg::FMPS_TACH_LOCK) ?
        lock_ind_ff : speed_pulse;
    // Open drain: only ever pull the line low
    assign tach_output_pin_o = 1'b0;
    assign tach_output_pin_oe = serial_mode_pin ? !(tach_lvl && ser_tx) :
        !(tach_lvl && ser_tx);
    assign ser_rx = serial_mode_pin ? pwm_pin_i : tach_output_pin_i;

    // ****************************************
    // APB read path
    // ****************************************
    logic [31:0] nxt_prdata;
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        case (wofs)
            `FMPS_OFS_CTRL: nxt_prdata = ctrl_ff;
            `FMPS_OFS_PROT: nxt_prdata = prot_ff;
            `FMPS_OFS_STAT: nxt_prdata = {24'h0, events_ff, gpc_err_ff,
                lock_ind_ff, climit_act, 2'(st_ff)};
            `FMPS_OFS_NVM: nxt_prdata = nvm_mem[0];
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= nxt_prdata;
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr[11:4] != 8'h00);

endmodule // fmps_supervisor

`default_nettype wire

// [rtl/fmps_cfg.svh]
`ifndef FMPS_CFG_SVH
`define FMPS_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FMPS_OFS_CTRL 12'h000
`define FMPS_OFS_PROT 12'h004
`define FMPS_OFS_STAT 12'h008
`define FMPS_OFS_NVM 12'h00c

// ****************************************
// Field positions
// ****************************************
`define FMPS_CTRL_TACH_PIN_FUNCTION_SELECT_LSB 0
`define FMPS_CTRL_DUTYS_LSB 4
`define FMPS_PROT_MASK_LSB 0
`define FMPS_PROT_RESP_BIT 2
`define FMPS_PROT_ASYNC_BIT 3
`define FMPS_PROT_HOLD_BIT 4

// ****************************************
// Reset values
// ****************************************
`define FMPS_CTRL_RST 32'h0000_00f0
`define FMPS_PROT_RST 32'h0000_0018

// ****************************************
// Times in their own units, clock in MHz
// ****************************************
`define FMPS_CLK_MHZ 100
`define FMPS_TICK_US 1000
`define FMPS_LOCK_DET_MS 300
`define FMPS_OFF_SHORT_MS 3500
`define FMPS_OFF_LONG_MS 14000
`define FMPS_TICK_CYC (`FMPS_TICK_US * `FMPS_CLK_MHZ)
`define FMPS_LOCK_DET_TICKS (`FMPS_LOCK_DET_MS * 1000 / `FMPS_TICK_US)
`define FMPS_OFF_SHORT_TICKS (`FMPS_OFF_SHORT_MS * 1000 / `FMPS_TICK_US)
`define FMPS_OFF_LONG_TICKS (`FMPS_OFF_LONG_MS * 1000 / `FMPS_TICK_US)
`define FMPS_RD_CLEAR_PHASES 4
`define FMPS_LONG_EVENT 5
`define FMPS_NVM_WORDS 4

`endif

// [rtl/fmps_pkg.sv]
package fmps_pkg;

    typedef enum logic [1:0] {
        FMPS_TACH_SPEED,
        FMPS_TACH_LOCK,
        FMPS_TACH_RSV2,
        FMPS_TACH_RSV3
    } fmps_tach_pin_function_select_t;

    typedef struct packed {
        logic high_gate_a;
        logic low_gate_a;
        logic high_gate_b;
        logic low_gate_b;
    } fmps_gates_t;

    typedef struct packed {
        logic over_limit;
        logic over_shutdown;
    } fmps_sense_t;

endpackage

// [verification/fmps_supervisor_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module fmps_supervisor_chk (
    // Clock, reset, APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Motor side and straps
    input wire fmps_pkg::fmps_sense_t current_sense_pin,
    input wire fmps_pkg::fmps_gates_t gates,
    input wire logic supply_class_high,
    input wire logic polarity_check_disable_pin,
    input wire logic high_gate_a_sense,
    // Link
    input wire logic serial_mode_pin,
    input wire logic pwm_pin_i,
    input wire logic tach_output_pin_i,
    input wire logic ser_rx
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // Sequences and properties
    // ****
    sequence s_lows_off;
        !gates.low_gate_a && !gates.low_gate_b;
    endsequence
    sequence s_gpc_bad;
        $rose(presetn) && !polarity_check_disable_pin
            && (high_gate_a_sense == supply_class_high);
    endsequence
    property p_ready;
        psel && penable |-> pready;
    endproperty
    property p_err_hi;
        psel && penable && paddr >= 12'h010 |-> pslverr;
    endproperty
    property p_err_lo;
        psel && penable && paddr < 12'h010 |-> !pslverr;
    endproperty
    property p_rd_hold;
        !psel |=> $stable(prdata);
    endproperty
    property p_rst_off;
        @(posedge pclk) disable iff (1'b0) !presetn |-> gates == 4'h0;
    endproperty
    // Blanking may hide the first cycles of a trip, hence the wide window
    property p_shut;
        current_sense_pin.over_shutdown [*8] |-> ##[0:60] s_lows_off;
    endproperty
    property p_gpc;
        s_gpc_bad |-> s_lows_off [*8];
    endproperty
    property p_link;
        ser_rx == (serial_mode_pin ? pwm_pin_i : tach_output_pin_i);
    endproperty
    property p_no_shoot;
        !supply_class_high |-> !(!gates.high_gate_a && gates.low_gate_a)
            && !(!gates.high_gate_b && gates.low_gate_b);
    endproperty
    // ****
    // Assertions
    // ****
    a_ready: assert property (p_ready)
        else $error("access without pready");
    a_err_hi: assert property (p_err_hi)
        else $error("no error on unmapped offset");
    a_err_lo: assert property (p_err_lo)
        else $error("error on mapped offset");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved while idle");
    a_rst_off: assert property (p_rst_off)
        else $error("gates active in reset");
    a_shut: assert property (p_shut)
        else $error("low gates on after trip");
    a_gpc: assert property (p_gpc)
        else $error("low gates on with bad polarity");
    a_link: assert property (p_link)
        else $error("link receive from wrong pin");
    a_no_shoot: assert property (p_no_shoot)
        else $error("both switches of a leg on");
endmodule // fmps_supervisor_chk

bind fmps_supervisor fmps_supervisor_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_sense_pin(current_sense_pin), .gates(gates),
    .supply_class_high(supply_class_high),
    .polarity_check_disable_pin(polarity_check_disable_pin),
    .high_gate_a_sense(high_gate_a_sense),
    .serial_mode_pin(serial_mode_pin), .pwm_pin_i(pwm_pin_i),
    .tach_output_pin_i(tach_output_pin_i), .ser_rx(ser_rx)
);
`default_nettype wire

// [verification/fmps_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fmps_host_model (
    // Clock
    input wire logic pclk,
    // Command from the bench
    input wire logic [7:0] cmd_duty,
    input wire logic link_pull,
    // Pins toward the device
    output logic [7:0] pwm_duty,
    output logic pwm_rise,
    output logic pwm_pin_i,
    output logic tach_pull_oe
);
    logic [5:0] ph_ff = 6'h00;

    // Short period keeps the test fast; duty is scaled by four
    always @(posedge pclk)
        ph_ff <= ph_ff + 6'h01;

    assign pwm_duty = cmd_duty;
    // A zero duty never rises, so stop really holds the pin low
    assign pwm_rise = (ph_ff == 6'h00) && (cmd_duty != 8'h00);
    assign pwm_pin_i = {ph_ff, 2'b00} < cmd_duty;
    // Host can only pull the shared line low
    assign tach_pull_oe = link_pull;
endmodule // fmps_host_model
`default_nettype wire

// [verification/fmps_supervisor_test.sv]
`timescale 1ns/1ns
`default_nettype none
module fmps_supervisor_test;
    localparam int TK = 2;
    localparam fmps_pkg::fmps_gates_t RUN = 4'b0011;
    localparam fmps_pkg::fmps_gates_t RCR = 4'b1011;
    localparam fmps_pkg::fmps_gates_t LCK = 4'b1010;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pwm_rise, hall, spd, pwm_pin, gpc_dis, sns_a, ser_mode, ser_rx;
    logic tach_i, tach_oe, host_oe, pull, cls;
    logic [7:0] pwm_duty, cmd_duty;
    fmps_pkg::fmps_sense_t sense;
    fmps_pkg::fmps_gates_t gates;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    // Shared tach line with pull-up
    assign tach_i = !(tach_oe || host_oe);

    fmps_supervisor #(.TICK_CYC(TK)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_duty(pwm_duty),
        .pwm_rise(pwm_rise), .hall_phase_change(hall),
        .current_sense_pin(sense), .run_gates(RUN), .recirc_gates(RCR),
        .gates(gates), .supply_class_high(cls),
        .polarity_check_disable_pin(gpc_dis), .high_gate_a_sense(sns_a),
        .high_gate_b_sense(1'b1), .serial_mode_pin(ser_mode),
        .speed_pulse(spd), .ser_tx(1'b1), .ser_rx(ser_rx),
        .tach_output_pin_i(tach_i), .tach_output_pin_o(),
        .tach_output_pin_oe(tach_oe), .pwm_pin_i(pwm_pin)
    );

    fmps_host_model host_u (
        .pclk(pclk), .cmd_duty(cmd_duty), .link_pull(pull),
        .pwm_duty(pwm_duty), .pwm_rise(pwm_rise), .pwm_pin_i(pwm_pin),
        .tach_pull_oe(host_oe)
    );
    // ****
    // Clock, timeout, shared tasks
    // ****
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 50)
        begin
            w++;
            @(posedge pclk);
        end
        if (w >= 50)
            err_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("register", x, q);
    endtask

    task stat(input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, 12'h008, 32'h0);
        chk("status", x, q & m);
    endtask

    task rst();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task wait_g(input fmps_pkg::fmps_gates_t g, input int lim);
        n = 0;
        while (gates !== g && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task spin(input int k);
        repeat (k)
        begin
            hall <= 1'b1;
            spd <= ~spd;
            @(posedge pclk);
            hall <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_regs();
        rd(12'h000, 32'h0000_00f0);
        rd(12'h004, 32'h0000_0018);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk("slverr", 32'h1, e);
        apb(1'b1, 12'h000, 32'h0000_0051);
        apb(1'b1, 12'h00c, 32'h8000_0000);
        rst();
        rd(12'h000, 32'h0000_0051);
        $display("regs test done");
    endtask

    task t_lock();
        cmd_duty <= 8'hc8;
        spin(8);
        chk("tach drive", 32'h1, tach_oe);
        wait_g(LCK, 2000);
        chk("lock delay", 32'h1, n >= 300 * TK - 8 && n <= 303 * TK);
        chk("lock gates", LCK, gates);
        chk("tach drive", 32'h0, tach_oe);
        stat(32'heb, 32'h29);
        wait_g(RUN, 8000);
        chk("off time", 32'h1, n >= 3490 * TK && n <= 3502 * TK + 70);
        spin(3);
        stat(32'h08, 32'h08);
        spin(1);
        stat(32'h08, 32'h00);
        $display("lock test done");
    endtask

    task t_stop();
        wait_g(LCK, 2000);
        stat(32'he0, 32'h40);
        cmd_duty <= 8'h00;
        repeat (70) @(posedge pclk);
        cmd_duty <= 8'hc8;
        n = 0;
        while (pwm_rise !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        stat(32'he3, 32'h21);
        wait_g(RUN, 8000);
        chk("off time", 32'h1, n >= 3490 * TK && n <= 3502 * TK + 70);
        $display("stop test done");
    endtask

    task t_ocp();
        rst();
        apb(1'b1, 12'h004, 32'h10);
        sense <= 2'b10;
        repeat (4) @(posedge pclk);
        chk("limit gates", RCR, gates);
        stat(32'h04, 32'h04);
        apb(1'b1, 12'h004, 32'h18);
        repeat (2) @(posedge pclk);
        chk("async gates", 32'ha, gates);
        sense <= 2'b00;
        // Latch first, then retry; each needs a fresh start
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, 12'h004, 32'h18 | (r << 2));
            sense <= 2'b11;
            repeat (10) @(posedge pclk);
            sense <= 2'b00;
            repeat (20) @(posedge pclk);
            chk("trip gates", LCK, gates);
            stat(32'h03, r ? 32'h1 : 32'h3);
            rst();
        end
        $display("overcurrent test done");
    endtask

    task t_gpc();
        sns_a <= 1'b0;
        rst();
        chk("low gates", 32'h0, {gates.low_gate_a, gates.low_gate_b});
        gpc_dis <= 1'b1;
        stat(32'h10, 32'h10);
        rst();
        stat(32'h10, 32'h00);
        cls <= 1'b1;
        @(posedge pclk);
        chk("hv run gates", RUN, gates);
        repeat (700) @(posedge pclk);
        chk("hv lock gates", 32'h0, gates);
        cls <= 1'b0;
        sns_a <= 1'b1;
        gpc_dis <= 1'b0;
        $display("polarity test done");
    endtask

    task t_link();
        for (int m = 0; m < 2; m++)
        begin
            ser_mode <= m[0];
            pull <= 1'b1;
            repeat (2) @(posedge pclk);
            chk("link rx", m ? pwm_pin : tach_i, ser_rx);
            pull <= 1'b0;
        end
        $display("link test done");
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hall = 1'b0;
        spd = 1'b0;
        sense = 2'b00;
        gpc_dis = 1'b0;
        sns_a = 1'b1;
        ser_mode = 1'b0;
        pull = 1'b0;
        cls = 1'b0;
        cmd_duty = 8'h00;
        rst();
        t_regs();
        t_lock();
        t_stop();
        t_ocp();
        t_gpc();
        t_link();
        report_and_stop();
    end
endmodule // fmps_supervisor_test
`default_nettype wire
